// >>> src/sdid_card.sv
// sdid_card: card side of the identification phase on the command line.
// Assumes the host drives sd_clk and cmd_in synchronous to sd_clk, and that
// rst is asserted at power-up; clk runs free at 200 MHz.
`timescale 1ns/1ps
`include "sdid_map.svh"
`default_nettype none
module sdid_card
#(
   parameter logic [119:0] IDENTITY = 120'h0123456789ABCDEF0123456789ABCD
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic sd_clk,
   input wire logic cmd_in,
   output logic cmd_out,
   output logic cmd_oe,
   output sdid_pkg::sdid_state_e card_state,
   output sdid_pkg::sdid_addr_t session_address,
   output logic [15:0] driver_stage,
   output logic id_mode,
   output logic powerup_busy
);
   import sdid_pkg::*;
   // identity value above is arbitrary

   localparam int PWR_CYC = `SDID_POWERUP_CYC;

   // core domain: power-up procedure and status mirror
   logic [11:0] pwr_cnt_r, pwr_cnt_nxt;
   logic done_r, done_nxt;
   logic tg_s1_r, tg_s2_r, tg_s3_r;
   sdid_state_e cs_r, cs_nxt;
   sdid_addr_t sa_r, sa_nxt;
   logic [15:0] ds_r, ds_nxt;

   // link domain
   sdid_state_e st_r, st_nxt;
   sdid_addr_t rca_r, rca_nxt;
   logic [15:0] dsr_r, dsr_nxt;
   logic app_r, app_nxt;
   logic lock_r, lock_nxt;
   logic [46:0] rx_sh_r, rx_sh_nxt;
   logic [5:0] rx_cnt_r, rx_cnt_nxt;
   logic rx_act_r, rx_act_nxt;
   logic [1:0] wait_r, wait_nxt;
   logic tx_act_r, tx_act_nxt;
   logic [127:0] tx_sh_r, tx_sh_nxt;
   logic [7:0] tx_pos_r, tx_pos_nxt;
   logic [7:0] tx_len_r, tx_len_nxt;
   logic [7:0] tx_skip_r, tx_skip_nxt;
   logic tx_ones_r, tx_ones_nxt;
   logic [6:0] crc_r, crc_nxt;
   logic [15:0] lfsr_r, lfsr_nxt;
   logic out_r, out_nxt;
   logic oe_r, oe_nxt;
   logic tog_r, tog_nxt;
   logic rdy_s1_r, rdy_s2_r;

   function automatic logic [3:0] state_code(input sdid_state_e s);
      logic [3:0] c;
      c = 4'h0;
      unique case (s)
         SDID_IDLE: c = 4'h0;
         SDID_READY: c = 4'h1;
         SDID_IDENT: c = 4'h2;
         SDID_STBY: c = 4'h3;
         SDID_INACT: c = 4'h0;
      endcase
      return c;
   endfunction

   // power-up procedure timer; busy until it runs out
   always_comb
   begin
      pwr_cnt_nxt = pwr_cnt_r;
      done_nxt = done_r;
      if (!done_r)
      begin
         if (pwr_cnt_r == 12'(PWR_CYC - 1))
         begin
            done_nxt = 1'b1;
         end
         else
         begin
            pwr_cnt_nxt = pwr_cnt_r + 12'h001;
         end
      end
   end

   // status mirror: link values stand still for a whole frame after the toggle
   always_comb
   begin
      cs_nxt = cs_r;
      sa_nxt = sa_r;
      ds_nxt = ds_r;
      if (tg_s2_r != tg_s3_r)
      begin
         cs_nxt = st_r;
         sa_nxt = rca_r;
         ds_nxt = dsr_r;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pwr_cnt_r <= 12'h000;
         done_r <= 1'b0;
         tg_s1_r <= 1'b0;
         tg_s2_r <= 1'b0;
         tg_s3_r <= 1'b0;
         cs_r <= SDID_IDLE;
         sa_r <= `SDID_ADDR_RESET;
         ds_r <= `SDID_DSR_RESET;
      end
      else
      begin
         pwr_cnt_r <= pwr_cnt_nxt;
         done_r <= done_nxt;
         tg_s1_r <= tog_r;
         tg_s2_r <= tg_s1_r;
         tg_s3_r <= tg_s2_r;
         cs_r <= cs_nxt;
         sa_r <= sa_nxt;
         ds_r <= ds_nxt;
      end
   end

   assign card_state = cs_r;
   assign session_address = sa_r;
   assign driver_stage = ds_r;
   assign id_mode = cs_r != SDID_STBY;
   assign powerup_busy = !done_r;
   assign cmd_out = out_r;
   assign cmd_oe = oe_r;

   // link domain: receive, decode, answer
   always_comb
   begin
      logic [47:0] fr;
      logic [5:0] idx;
      logic [31:0] arg;
      logic hit;
      logic b;
      logic fb;
      logic [39:0] body;
      logic answer;
      fr = {rx_sh_r, cmd_in};
      idx = fr[45:40];
      arg = fr[39:8];
      hit = arg[31:16] == rca_r;
      b = 1'b1;
      fb = 1'b0;
      body = 40'h0;
      answer = 1'b0;
      st_nxt = st_r;
      rca_nxt = rca_r;
      dsr_nxt = dsr_r;
      app_nxt = app_r;
      lock_nxt = lock_r;
      rx_sh_nxt = rx_sh_r;
      rx_cnt_nxt = rx_cnt_r;
      rx_act_nxt = rx_act_r;
      wait_nxt = wait_r;
      tx_act_nxt = tx_act_r;
      tx_sh_nxt = tx_sh_r;
      tx_pos_nxt = tx_pos_r;
      tx_len_nxt = tx_len_r;
      tx_skip_nxt = tx_skip_r;
      tx_ones_nxt = tx_ones_r;
      crc_nxt = crc_r;
      lfsr_nxt = {1'b0, lfsr_r[15:1]} ^ (lfsr_r[0] ? `SDID_LFSR_TAPS : 16'h0000);
      out_nxt = 1'b1;
      oe_nxt = 1'b0;
      tog_nxt = tog_r;
      // own drive is never mistaken for a start bit
      if (!rx_act_r && !tx_act_r && !oe_r && wait_r == 2'h0 && !cmd_in)
      begin
         rx_act_nxt = 1'b1;
         rx_cnt_nxt = 6'h01;
         rx_sh_nxt = {rx_sh_r[45:0], cmd_in};
      end
      else if (rx_act_r)
      begin
         rx_sh_nxt = {rx_sh_r[45:0], cmd_in};
         rx_cnt_nxt = rx_cnt_r + 6'h01;
         if (rx_cnt_r == `SDID_FRAME_LAST)
         begin
            rx_act_nxt = 1'b0;
            // a malformed frame is dropped whole
            if (fr[47:46] == 2'b01 && fr[0] && st_r != SDID_INACT)
            begin
               app_nxt = 1'b0;
               unique case (idx)
                  `SDID_CMD_GO_IDLE:
                  begin
                     st_nxt = SDID_IDLE;
                     rca_nxt = `SDID_ADDR_RESET;
                     dsr_nxt = `SDID_DSR_RESET;
                     lock_nxt = 1'b0;
                  end
                  `SDID_CMD_APP:
                  begin
                     if (hit)
                     begin
                        app_nxt = 1'b1;
                        answer = 1'b1;
                        body = {2'b01, idx, 32'(state_code(st_r)) << `SDID_STATE_LSB};
                        body[`SDID_APP_BIT] = 1'b1;
                     end
                  end
                  `SDID_CMD_OP_COND:
                  begin
                     // only right after the prefix, and only in Idle
                     if (app_r && st_r == SDID_IDLE)
                     begin
                        if (arg[23:0] != 24'h0 && !lock_r && (arg[23:0] & `SDID_OCR_WINDOW) == 24'h0)
                        begin
                           st_nxt = SDID_INACT;
                        end
                        else
                        begin
                           answer = 1'b1;
                           body = {2'b01, `SDID_IDX_LONG, 8'h00, `SDID_OCR_WINDOW};
                           body[`SDID_OCR_READY_BIT] = rdy_s2_r;
                           if (arg[23:0] != 24'h0)
                           begin
                              lock_nxt = 1'b1;
                              if (rdy_s2_r)
                              begin
                                 st_nxt = SDID_READY;
                              end
                           end
                        end
                     end
                  end
                  `SDID_CMD_SEND_ID:
                  begin
                     if (st_r == SDID_READY)
                     begin
                        st_nxt = SDID_IDENT;
                     end
                  end
                  `SDID_CMD_PUBLISH:
                  begin
                     if (st_r == SDID_IDENT || st_r == SDID_STBY)
                     begin
                        st_nxt = SDID_STBY;
                        rca_nxt = lfsr_r;
                        answer = 1'b1;
                        body = {2'b01, idx, lfsr_r, 16'(state_code(st_r)) << `SDID_STATE_LSB};
                     end
                  end
                  `SDID_CMD_DEACT:
                  begin
                     if (hit)
                     begin
                        st_nxt = SDID_INACT;
                     end
                  end
                  default:
                  begin
                  end
               endcase
               if (idx == `SDID_CMD_SEND_ID && st_r == SDID_READY)
               begin
                  wait_nxt = `SDID_NCR;
                  tx_sh_nxt = {2'b01, `SDID_IDX_LONG, IDENTITY};
                  tx_len_nxt = `SDID_LONG_BODY;
                  tx_skip_nxt = `SDID_LONG_SKIP;
                  tx_ones_nxt = 1'b0;
               end
               else if (answer)
               begin
                  wait_nxt = `SDID_NCR;
                  tx_sh_nxt = {body, 88'h0};
                  tx_len_nxt = `SDID_SHORT_BODY;
                  tx_skip_nxt = 8'h00;
                  tx_ones_nxt = idx == `SDID_CMD_OP_COND;
               end
               if (st_nxt != st_r || rca_nxt != rca_r || dsr_nxt != dsr_r)
               begin
                  tog_nxt = !tog_r;
               end
            end
         end
      end
      if (wait_r != 2'h0)
      begin
         wait_nxt = wait_r - 2'h1;
         if (wait_r == 2'h1)
         begin
            tx_act_nxt = 1'b1;
            tx_pos_nxt = 8'h00;
            crc_nxt = 7'h00;
         end
      end
      // push-pull drive of the answer, msb first
      if (tx_act_r)
      begin
         oe_nxt = 1'b1;
         tx_pos_nxt = tx_pos_r + 8'h01;
         if (tx_pos_r < tx_len_r)
         begin
            b = tx_sh_r[127];
            tx_sh_nxt = {tx_sh_r[126:0], 1'b0};
            if (tx_pos_r >= tx_skip_r)
            begin
               fb = b ^ crc_r[6];
               crc_nxt = {crc_r[5:0], 1'b0} ^ (fb ? `SDID_CRC_POLY : 7'h00);
            end
         end
         else if (tx_pos_r < tx_len_r + `SDID_CRC_BITS)
         begin
            b = tx_ones_r | crc_r[6];
            crc_nxt = {crc_r[5:0], 1'b0};
         end
         else
         begin
            tx_act_nxt = 1'b0;
         end
         out_nxt = b;
      end
   end

   always_ff @(posedge sd_clk or posedge rst)
   begin
      if (rst)
      begin
         st_r <= SDID_IDLE;
         rca_r <= `SDID_ADDR_RESET;
         dsr_r <= `SDID_DSR_RESET;
         app_r <= 1'b0;
         lock_r <= 1'b0;
         rx_sh_r <= 47'h0;
         rx_cnt_r <= 6'h00;
         rx_act_r <= 1'b0;
         wait_r <= 2'h0;
         tx_act_r <= 1'b0;
         tx_sh_r <= 128'h0;
         tx_pos_r <= 8'h00;
         tx_len_r <= 8'h00;
         tx_skip_r <= 8'h00;
         tx_ones_r <= 1'b0;
         crc_r <= 7'h00;
         lfsr_r <= `SDID_LFSR_SEED;
         out_r <= 1'b1;
         oe_r <= 1'b0;
         tog_r <= 1'b0;
         rdy_s1_r <= 1'b0;
         rdy_s2_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         rca_r <= rca_nxt;
         dsr_r <= dsr_nxt;
         app_r <= app_nxt;
         lock_r <= lock_nxt;
         rx_sh_r <= rx_sh_nxt;
         rx_cnt_r <= rx_cnt_nxt;
         rx_act_r <= rx_act_nxt;
         wait_r <= wait_nxt;
         tx_act_r <= tx_act_nxt;
         tx_sh_r <= tx_sh_nxt;
         tx_pos_r <= tx_pos_nxt;
         tx_len_r <= tx_len_nxt;
         tx_skip_r <= tx_skip_nxt;
         tx_ones_r <= tx_ones_nxt;
         crc_r <= crc_nxt;
         lfsr_r <= lfsr_nxt;
         out_r <= out_nxt;
         oe_r <= oe_nxt;
         tog_r <= tog_nxt;
         rdy_s1_r <= done_r;
         rdy_s2_r <= rdy_s1_r;
      end
   end
endmodule
`default_nettype wire

// >>> src/sdid_map.svh
// sdid_map.svh: offsets, field positions, reset values and timing counts
// for the card-side identification logic. Included by src/sdid_card.sv.
//
// Notes on behaviour
// - software reset command returns the card to Idle from any state but Inactive.
// - in Inactive the software reset command is ignored.
// - power-up always starts in Idle, even after Inactive.
// - after power-up or software reset the command driver is released, awaiting a start bit.
// - power-up or software reset sets session address 0x0000 and default driver stage.
// - operating-condition command with an unsupported window sends the card to Inactive.
// - operating-condition command with empty window only reports, never deactivates.
// - operating-condition answer carries the operating condition register.
// - busy bit reads 0 while power-up runs; host repeats until it is set.
// - later changes of the requested window are ignored during initialization.
// - Inactive is left only by a power cycle.
// - addressed deactivation command puts the card into Inactive.
// - identity request in Ready answers the identity number, then goes Identification.
// - address publication gives a new session address and enters Stand-by.
// - in Stand-by each further publication yields a new address, the last one counts.
// - identification uses the command line only, no data lines.
// - the command line output is push-pull.
// - command frames are 48 bits, start bit 0, end bit 1.
// - response frames are 48 or 136 bits long.
// - frames go most significant bit first.
// - identification mode lasts until address publication, then data transfer mode.
`ifndef SDID_MAP_SVH
`define SDID_MAP_SVH

`define SDID_CMD_GO_IDLE 6'h00
`define SDID_CMD_SEND_ID 6'h02
`define SDID_CMD_PUBLISH 6'h03
`define SDID_CMD_DEACT 6'h0F
`define SDID_CMD_APP 6'h37
`define SDID_CMD_OP_COND 6'h29
`define SDID_IDX_LONG 6'h3F

`define SDID_FRAME_LAST 6'h2F
`define SDID_SHORT_BODY 8'h28
`define SDID_LONG_BODY 8'h80
`define SDID_CRC_BITS 8'h07
`define SDID_LONG_SKIP 8'h08
`define SDID_NCR 2'h2

`define SDID_ADDR_RESET 16'h0000
`define SDID_DSR_RESET 16'h0404
`define SDID_OCR_WINDOW 24'hFF8000
`define SDID_OCR_READY_BIT 31
`define SDID_APP_BIT 5
`define SDID_STATE_LSB 9
`define SDID_LFSR_SEED 16'hACE1
`define SDID_LFSR_TAPS 16'hB400
`define SDID_CRC_POLY 7'h09

`define SDID_CLK_MHZ 200
`define SDID_POWERUP_NS 2000
`define SDID_POWERUP_CYC ((`SDID_POWERUP_NS * `SDID_CLK_MHZ + 999) / 1000)

`endif

// >>> src/sdid_pkg.sv
// sdid_pkg: types shared by the card-side identification logic.
// Assumes nothing beyond a SystemVerilog compiler.
package sdid_pkg;
   typedef enum logic [4:0]
   {
      SDID_IDLE = 5'h01,
      SDID_READY = 5'h02,
      SDID_IDENT = 5'h04,
      SDID_STBY = 5'h08,
      SDID_INACT = 5'h10
   } sdid_state_e;
   typedef logic [15:0] sdid_addr_t;
endpackage

// >>> bench/sdid_card_monitor.sv
// sdid_card_monitor: concurrent checks on the ports of sdid_card.
// Assumes rst is asynchronous, active high, and resets both clock domains.
`timescale 1ns/1ps
`default_nettype none
module sdid_card_monitor
(
   input wire logic clk,
   input wire logic rst,
   input wire logic sd_clk,
   input wire logic cmd_in,
   input wire logic cmd_out,
   input wire logic cmd_oe,
   input wire sdid_pkg::sdid_state_e card_state,
   input wire sdid_pkg::sdid_addr_t session_address,
   input wire logic [15:0] driver_stage,
   input wire logic id_mode,
   input wire logic powerup_busy
);
   import sdid_pkg::*;
   logic [7:0] oe_cnt_r;
   logic [7:0] oe_cnt_nxt;
   logic [8:0] up_cnt_r;
   logic [8:0] up_cnt_nxt;

   // length of the current drive burst, in link cycles
   always_comb
   begin
      oe_cnt_nxt = cmd_oe ? oe_cnt_r + 8'h01 : 8'h00;
   end
   always_ff @(posedge sd_clk or posedge rst)
   begin
      if (rst)
         oe_cnt_r <= 8'h00;
      else
         oe_cnt_r <= oe_cnt_nxt;
   end

   // saturates so the busy bound stays meaningful long after power-up
   always_comb
   begin
      up_cnt_nxt = (up_cnt_r == 9'h1FF) ? up_cnt_r : up_cnt_r + 9'h001;
   end
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         up_cnt_r <= 9'h000;
      else
         up_cnt_r <= up_cnt_nxt;
   end

   a_inact_quiet:
   assert property (@(posedge clk) disable iff (rst) card_state == SDID_INACT |-> !cmd_oe)
      else $error("line driven while inactive");
   a_inact_stays:
   assert property (@(posedge clk) disable iff (rst) card_state == SDID_INACT |=> card_state == SDID_INACT)
      else $error("inactive state left");
   a_idle_defaults:
   assert property (@(posedge clk) disable iff (rst)
      card_state == SDID_IDLE |-> session_address == 16'h0000 && driver_stage == 16'h0404)
      else $error("idle without default address or stage");
   a_id_mode_flag:
   assert property (@(posedge clk) disable iff (rst) id_mode == (card_state != SDID_STBY))
      else $error("mode flag wrong");
   a_busy_max:
   assert property (@(posedge clk) disable iff (rst) powerup_busy |-> up_cnt_r <= 9'h192)
      else $error("power-up busy too long");
   a_busy_min:
   assert property (@(posedge clk) disable iff (rst) $fell(powerup_busy) |-> up_cnt_r >= 9'h18E)
      else $error("power-up busy too short");
   a_start_bit:
   assert property (@(posedge sd_clk) disable iff (rst) $rose(cmd_oe) |-> !cmd_out)
      else $error("answer without start bit");
   a_end_bit:
   assert property (@(posedge sd_clk) disable iff (rst) $fell(cmd_oe) |-> $past(cmd_out) && cmd_out)
      else $error("answer without end bit");
   a_resp_len:
   assert property (@(posedge sd_clk) disable iff (rst) $fell(cmd_oe) |-> oe_cnt_r == 8'h30 || oe_cnt_r == 8'h88)
      else $error("answer length wrong");
   a_ncr_gap:
   assert property (@(posedge sd_clk) disable iff (rst) $rose(cmd_oe) |-> $past(cmd_in, 1) && $past(cmd_in, 3))
      else $error("answer not after idle gap");
endmodule

bind sdid_card sdid_card_monitor mon_u
(
   .clk(clk), .rst(rst), .sd_clk(sd_clk), .cmd_in(cmd_in), .cmd_out(cmd_out), .cmd_oe(cmd_oe),
   .card_state(card_state), .session_address(session_address), .driver_stage(driver_stage),
   .id_mode(id_mode), .powerup_busy(powerup_busy)
);
`default_nettype wire

// >>> bench/sdid_host.sv
// sdid_host: behavioural host driving the link clock and the command line.
// Assumes a pull-up on the line; the clock only runs inside xfer transfers and clocks bursts.
`timescale 1ns/1ps
`default_nettype none
module sdid_host
(
   output var logic sd_clk,
   output wire logic line,
   input wire logic cmd_out,
   input wire logic cmd_oe
);
   logic run = 1'b0;
   logic hoe = 1'b0;
   logic hv = 1'b1;

   assign line = cmd_oe ? cmd_out : (hoe ? hv : 1'b1);

   // slow identification rate, stops low between transfers
   initial
   begin
      sd_clk = 1'b0;
      #2;
      forever
      begin
         #15;
         if (run || sd_clk)
            sd_clk = ~sd_clk;
      end
   end

   task automatic clocks(input int n);
      run = 1'b1;
      repeat (n) @(negedge sd_clk);
      run = 1'b0;
   endtask

   // sampled mid-bit on the falling edge, clear of the card's launch edge
   task automatic xfer(input logic [5:0] idx, input logic [31:0] arg, input int len,
      output logic [135:0] rsp, output int got);
      logic [47:0] f;
      f = {2'b01, idx, arg, 7'h00, 1'b1};
      rsp = '0;
      got = 0;
      run = 1'b1;
      for (int i = 47; i >= 0; i--)
      begin
         hoe = 1'b1;
         hv = f[i];
         @(negedge sd_clk);
      end
      hoe = 1'b0;
      repeat (8)
      begin
         @(negedge sd_clk);
         if (line === 1'b0)
            break;
      end
      if (line === 1'b0)
      begin
         got = 1;
         repeat (len)
         begin
            rsp = {rsp[134:0], line};
            @(negedge sd_clk);
         end
      end
      repeat (4) @(negedge sd_clk);
      run = 1'b0;
   endtask
endmodule
`default_nettype wire

// >>> bench/tb.sv
// tb: self-checking bench for sdid_card with a behavioural host.
// Assumes the monitor is bound by its own file.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
   $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb;
   import sdid_pkg::*;
   localparam logic [119:0] IDV = 120'h0F1E2D3C4B5A69788796A5B4C3D2E1; // arbitrary
   logic clk;
   logic rst;
   wire sd_clk;
   wire cmd_in;
   logic cmd_out;
   logic cmd_oe;
   sdid_state_e card_state;
   sdid_addr_t session_address;
   logic [15:0] driver_stage;
   logic id_mode;
   logic powerup_busy;
   logic [135:0] r;
   logic [15:0] a1;
   int got;
   int n_errors = 0;
   int comparisons = 0;
   int cyc = 0;

   sdid_card #(.IDENTITY(IDV)) dut_u
   (
      .clk(clk), .rst(rst), .sd_clk(sd_clk), .cmd_in(cmd_in), .cmd_out(cmd_out), .cmd_oe(cmd_oe),
      .card_state(card_state), .session_address(session_address), .driver_stage(driver_stage),
      .id_mode(id_mode), .powerup_busy(powerup_busy)
   );
   sdid_host host_u
   (
      .sd_clk(sd_clk), .line(cmd_in), .cmd_out(cmd_out), .cmd_oe(cmd_oe)
   );

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic tally_and_finish;
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         n_errors++;
         tally_and_finish;
      end
   end

   // mirrors lag the link by a few core cycles
   task automatic cmd(input logic [5:0] i, input logic [31:0] a, input int len);
      host_u.xfer(i, a, len, r, got);
      repeat (20) @(negedge clk);
   endtask

   task automatic app41(input logic [23:0] w, input int len);
      cmd(6'h37, 32'h0000_0000, 48);
      `CHK("prefix", 7'h6F, {r[45:40], r[13]})
      cmd(6'h29, {8'h00, w}, len);
   endtask

   task automatic do_reset;
      rst = 1'b1;
      host_u.clocks(3);
      @(negedge clk);
      `CHK("busy", 1'b1, powerup_busy)
      rst = 1'b0;
      host_u.clocks(80);
      @(negedge clk);
      `CHK("state", SDID_IDLE, card_state)
      `CHK("addr", 16'h0000, session_address)
      `CHK("stage", 16'h0404, driver_stage)
      `CHK("oe", 1'b0, cmd_oe)
      `CHK("mode", 1'b1, id_mode)
      `CHK("busy", 1'b0, powerup_busy)
   endtask

   // power-up is over before the first legal command, so ready already shows
   task automatic t_query;
      app41(24'h000000, 48);
      `CHK("got", 1, got)
      `CHK("idx", 6'h3F, r[45:40])
      `CHK("ocr", 32'h80FF8000, r[39:8])
      `CHK("tail", 8'hFF, r[7:0])
      `CHK("state", SDID_IDLE, card_state)
      app41(24'hFF8000, 48);
      for (int k = 0; k < 4 && r[39] !== 1'b1; k++)
         app41(24'hFF8000, 48);
      `CHK("ready", 1'b1, r[39])
      `CHK("state", SDID_READY, card_state)
   endtask

   task automatic t_ident;
      cmd(6'h03, 32'h0, 0);
      `CHK("got", 0, got)
      cmd(6'h02, 32'h0, 136);
      `CHK("got", 1, got)
      `CHK("head", 8'h7F, r[135:128])
      `CHK("cid", IDV, r[127:8])
      `CHK("end", 1'b1, r[0])
      `CHK("state", SDID_IDENT, card_state)
   endtask

   task automatic t_publish;
      cmd(6'h03, 32'h0, 48);
      `CHK("idx", 6'h03, r[45:40])
      `CHK("status", 16'h0400, r[23:8])
      `CHK("addr", r[39:24], session_address)
      `CHK("state", SDID_STBY, card_state)
      `CHK("mode", 1'b0, id_mode)
      a1 = r[39:24];
      cmd(6'h03, 32'h0, 48);
      `CHK("status", 16'h0600, r[23:8])
      `CHK("addr", r[39:24], session_address)
      `CHK("newaddr", 1'b1, r[39:24] !== a1)
      cmd(6'h02, 32'h0, 0);
      `CHK("got", 0, got)
   endtask

   task automatic t_inactive;
      cmd(6'h00, 32'h0, 0);
      `CHK("state", SDID_IDLE, card_state)
      `CHK("addr", 16'h0000, session_address)
      app41(24'h000100, 0);
      `CHK("got", 0, got)
      `CHK("state", SDID_INACT, card_state)
      cmd(6'h00, 32'h0, 0);
      `CHK("state", SDID_INACT, card_state)
      cmd(6'h37, 32'h0, 48);
      `CHK("got", 0, got)
      do_reset;
      cmd(6'h0F, 32'h0, 0);
      `CHK("state", SDID_INACT, card_state)
   endtask

   initial
   begin
      do_reset;
      t_query;
      t_ident;
      t_publish;
      t_inactive;
      tally_and_finish;
   end
endmodule
`default_nettype wire
